// ===== mlim_pkg.sv
package mlim_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_LIMIT_FIRST = 8'h0B;
   localparam logic [7:0] REG_LIMIT_LAST = 8'h25;
   localparam logic [7:0] REG_HYST_IN0 = 8'h0D;
   localparam logic [7:0] REG_HYST_IN1 = 8'h10;
   localparam logic [7:0] REG_HYST_IN2 = 8'h13;
   localparam logic [7:0] REG_HYST_IN3 = 8'h16;
   localparam logic [7:0] REG_TEMP1_OFFSET = 8'h26;
   localparam logic [7:0] REG_TEMP2_OFFSET = 8'h27;
   localparam logic [7:0] REG_PWRDN = 8'h0A;
   localparam int PWRDN_FULL_BIT = 7;
   localparam logic [7:0] PWRDN_RESET = 8'h30;
   localparam int NUM_LIMIT_REGS = 27;
   // ---------------------------------------------------------------
   // Limit reset values
   // ---------------------------------------------------------------
   localparam logic [11:0] LIM_SE_HIGH = 12'hFFF;
   localparam logic [11:0] LIM_SE_LOW = 12'h000;
   localparam logic [11:0] LIM_DIFF_HIGH = 12'h7FF;
   localparam logic [11:0] LIM_DIFF_LOW = 12'h800;
   localparam logic [11:0] LIM_TEMP_HIGH = 12'h3FF;
   localparam logic [11:0] LIM_TEMP_LOW = 12'h400;
   localparam logic [11:0] HYST_MINMAX = 12'hFFF;
   localparam logic [11:0] HYST_RESET = 12'h008;
   // ---------------------------------------------------------------
   // Field layout of a 16-bit limit word
   // ---------------------------------------------------------------
   localparam int ALERT_BIT = 15;
   localparam int VALUE_W = 12;
   // ---------------------------------------------------------------
   // Addressing
   // ---------------------------------------------------------------
   localparam logic [6:0] ADDR_BASE = 7'h61;
   localparam logic [1:0] ADDR_MSB_RUN = 2'h3;
   localparam logic [1:0] ADDR_MSB_PWRDN = 2'h0;
   localparam logic [1:0] STRAP_LOW = 2'h0;
   localparam logic [1:0] STRAP_HIGH = 2'h1;
   localparam logic [1:0] STRAP_FLOAT = 2'h2;
   // ---------------------------------------------------------------
   // Master timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int SCL_PERIOD_NS = 2500;
   localparam int SCL_QUARTER = SCL_PERIOD_NS * CLK_MHZ / 1000 / 4;
endpackage

// ===== mlim_if.sv
`timescale 1ns/1ps
interface mlim_if;
   logic scl_out;
   logic scl_oe;
   logic sda_m_out;
   logic sda_m_oe;
   logic sda_s_out;
   logic sda_s_oe;
   wire scl = !(scl_oe && !scl_out);
   wire sda = !((sda_m_oe && !sda_m_out) || (sda_s_oe && !sda_s_out));
   modport slave (input scl, input sda, output sda_s_out, output sda_s_oe);
   modport master (input scl, input sda, output scl_out, output scl_oe, output sda_m_out, output sda_m_oe);
endinterface

// ===== mlim_slave.sv
`timescale 1ns/1ps
module mlim_slave #(
   parameter bit [3:0] DIFF_MODE = 4'h0
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   mlim_if.slave bus,
   input wire logic [1:0] addr_strap_msb_in,
   input wire logic [1:0] addr_strap_mid_in,
   input wire logic [1:0] addr_strap_lsb_in,
   input wire logic [11:0] temp_a_raw_in,
   input wire logic [11:0] temp_b_raw_in,
   input wire logic temp_valid_in,
   output logic [11:0] temp_a_result_out,
   output logic [11:0] temp_b_result_out,
   output logic [3:0] minmax_mode_out,
   output logic [6:0] slave_addr_out
);
   localparam int NUM_W = mlim_pkg::NUM_LIMIT_REGS;
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_PTR, S_WDATA, S_RDATA, S_IGNORE} mlim_st_t;
   typedef struct packed {
      logic [1:0][5:0] strap_s;
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic scl_d;
      logic sda_d;
      mlim_st_t st;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic rw;
      logic ack_phase;
      logic drive;
      logic dval;
      logic [7:0] ptr;
      logic hi_byte;
      logic [7:0] hold;
      logic [NUM_W-1:0][15:0] lim;
      logic [7:0] off_a;
      logic [7:0] off_b;
      logic [7:0] pwrdn;
      logic [11:0] res_a;
      logic [11:0] res_b;
      logic [6:0] saddr;
      logic [3:0] mm;
   } mlim_s_state_t;
   mlim_s_state_t r;
   mlim_s_state_t next_r;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] lim_default(input int i);
      int ch;
      ch = i / 3;
      if (ch >= 6)
         lim_default = (i % 3 == 0) ? {4'h0, mlim_pkg::LIM_TEMP_HIGH}
            : (i % 3 == 1) ? {4'h0, mlim_pkg::LIM_TEMP_LOW} : {4'h0, mlim_pkg::HYST_RESET};
      else if (ch >= 4 || DIFF_MODE[ch[1:0]])
         lim_default = (i % 3 == 0) ? {4'h0, mlim_pkg::LIM_DIFF_HIGH}
            : (i % 3 == 1) ? {4'h0, mlim_pkg::LIM_DIFF_LOW} : {4'h0, mlim_pkg::HYST_RESET};
      else
         lim_default = (i % 3 == 0) ? {4'h0, mlim_pkg::LIM_SE_HIGH}
            : (i % 3 == 1) ? {4'h0, mlim_pkg::LIM_SE_LOW} : {4'h0, mlim_pkg::HYST_RESET};
   endfunction

   function automatic logic [4:0] strap_digit(input logic [1:0] s);
      strap_digit = (s == mlim_pkg::STRAP_HIGH) ? 5'h01 : (s == mlim_pkg::STRAP_FLOAT) ? 5'h02 : 5'h00;
   endfunction

   function automatic logic is_limit(input logic [7:0] p);
      is_limit = p >= mlim_pkg::REG_LIMIT_FIRST && p <= mlim_pkg::REG_LIMIT_LAST;
   endfunction

   function automatic logic [11:0] apply_offset(input logic [11:0] raw, input logic [7:0] off);
      apply_offset = raw - {{4{off[7]}}, off};
   endfunction

   logic [4:0] idx;
   logic [6:0] strap_addr;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   assign idx = 5'(r.ptr - mlim_pkg::REG_LIMIT_FIRST);
   assign strap_addr = 7'(mlim_pkg::ADDR_BASE[4:0] + 5'(9 * strap_digit(r.strap_s[1][5:4])
      + 3 * strap_digit(r.strap_s[1][3:2]) + strap_digit(r.strap_s[1][1:0])));
   assign scl_rise = r.scl_s[1] && !r.scl_d;
   assign scl_fall = !r.scl_s[1] && r.scl_d;
   assign start_ev = r.scl_s[1] && r.scl_d && r.sda_d && !r.sda_s[1];
   assign stop_ev = r.scl_s[1] && r.scl_d && !r.sda_d && r.sda_s[1];

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      next_r = r;
      next_r.scl_s = {r.scl_s[0], bus.scl};
      next_r.sda_s = {r.sda_s[0], bus.sda};
      next_r.strap_s = {r.strap_s[0], addr_strap_msb_in, addr_strap_mid_in, addr_strap_lsb_in};
      next_r.mm = {r.lim[11][11:0] == mlim_pkg::HYST_MINMAX, r.lim[8][11:0] == mlim_pkg::HYST_MINMAX,
         r.lim[5][11:0] == mlim_pkg::HYST_MINMAX, r.lim[2][11:0] == mlim_pkg::HYST_MINMAX};
      next_r.scl_d = r.scl_s[1];
      next_r.sda_d = r.sda_s[1];
      next_r.saddr = {(r.pwrdn[mlim_pkg::PWRDN_FULL_BIT] ? mlim_pkg::ADDR_MSB_PWRDN : mlim_pkg::ADDR_MSB_RUN),
         strap_addr[4:0]};
      if (temp_valid_in)
      begin
         next_r.res_a = apply_offset(temp_a_raw_in, r.off_a);
         next_r.res_b = apply_offset(temp_b_raw_in, r.off_b);
      end
      if (start_ev)
      begin
         next_r.st = S_ADDR;
         next_r.bitn = 4'h0;
         next_r.ack_phase = 1'b0;
         next_r.drive = 1'b0;
      end
      else if (stop_ev)
      begin
         next_r.st = S_IDLE;
         next_r.drive = 1'b0;
      end
      else if (r.st != S_IDLE && r.st != S_IGNORE && scl_rise && !r.ack_phase)
      begin
         next_r.sh = {r.sh[6:0], r.sda_s[1]};
         next_r.bitn = r.bitn + 4'h1;
      end
      else if (r.st != S_IDLE && r.st != S_IGNORE && scl_rise && r.ack_phase && r.st == S_RDATA)
      begin
         if (r.sda_s[1])
            next_r.st = S_IGNORE;
      end
      else if (r.st != S_IDLE && r.st != S_IGNORE && scl_fall)
      begin
         if (r.ack_phase)
         begin
            next_r.ack_phase = 1'b0;
            next_r.bitn = 4'h0;
            next_r.drive = (r.st == S_RDATA) && !r.sh[7] ? 1'b1 : 1'b0;
            if (r.st == S_RDATA)
            begin
               next_r.sh = {r.sh[6:0], 1'b1};
               next_r.drive = !r.sh[7];
            end
         end
         else if (r.bitn == 4'h8)
         begin
            next_r.ack_phase = 1'b1;
            next_r.drive = 1'b1;
            case (r.st)
               S_ADDR:
               begin
                  if (r.sh[7:1] != r.saddr)
                  begin
                     next_r.st = S_IGNORE;
                     next_r.drive = 1'b0;
                  end
                  else if (r.sh[0])
                  begin
                     next_r.st = S_RDATA;
                     next_r.hi_byte = 1'b1;
                  end
                  else
                     next_r.st = S_PTR;
               end
               S_PTR:
               begin
                  next_r.ptr = r.sh;
                  next_r.hi_byte = 1'b1;
                  next_r.st = S_WDATA;
               end
               S_WDATA:
               begin
                  if (is_limit(r.ptr) && r.hi_byte)
                  begin
                     next_r.hold = r.sh;
                     next_r.hi_byte = 1'b0;
                  end
                  else
                  begin
                     if (is_limit(r.ptr))
                        next_r.lim[idx] = {r.lim[idx][15], 3'h0, r.hold[3:0], r.sh};
                     else if (r.ptr == mlim_pkg::REG_TEMP1_OFFSET)
                        next_r.off_a = r.sh;
                     else if (r.ptr == mlim_pkg::REG_TEMP2_OFFSET)
                        next_r.off_b = r.sh;
                     else if (r.ptr == mlim_pkg::REG_PWRDN)
                        next_r.pwrdn = r.sh;
                     next_r.st = S_PTR;
                  end
               end
               default:
                  next_r.drive = 1'b0;
            endcase
         end
         else if (r.st == S_RDATA)
            next_r.drive = !r.sh[7];
         if (r.ack_phase && r.st == S_RDATA)
         begin
            // Load next byte of the pointed register, upper byte first
            if (is_limit(r.ptr))
               next_r.sh = r.hi_byte ? {r.lim[idx][15], 3'h0, r.lim[idx][11:8]} : r.lim[idx][7:0];
            else if (r.ptr == mlim_pkg::REG_TEMP1_OFFSET)
               next_r.sh = r.off_a;
            else if (r.ptr == mlim_pkg::REG_TEMP2_OFFSET)
               next_r.sh = r.off_b;
            else if (r.ptr == mlim_pkg::REG_PWRDN)
               next_r.sh = r.pwrdn;
            else
               next_r.sh = 8'h00;
            next_r.hi_byte = is_limit(r.ptr) ? !r.hi_byte : 1'b1;
            next_r.drive = 1'b0;
            next_r.dval = 1'b1;
         end
      end
      if (r.dval && !(scl_fall && r.ack_phase))
      begin
         next_r.dval = 1'b0;
         next_r.drive = !r.sh[7];
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         r <= '0;
         r.scl_s <= 2'h3;
         r.sda_s <= 2'h3;
         r.scl_d <= 1'b1;
         r.sda_d <= 1'b1;
         r.st <= S_IDLE;
         r.pwrdn <= mlim_pkg::PWRDN_RESET;
         for (int i = 0; i < NUM_W; i++)
            r.lim[i] <= lim_default(i);
      end
      else
         r <= next_r;
   end

   assign bus.sda_s_out = 1'b0;
   assign bus.sda_s_oe = r.drive;
   assign temp_a_result_out = r.res_a;
   assign temp_b_result_out = r.res_b;
   assign slave_addr_out = r.saddr;
   assign minmax_mode_out = r.mm;
endmodule

// ===== mlim_master.sv
`timescale 1ns/1ps
module mlim_master (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   mlim_if.master bus,
   input wire logic go_in,
   input wire logic [6:0] addr_in,
   input wire logic rd_in,
   input wire logic [3:0] nbytes_in,
   input wire logic [31:0] wdata_in,
   output logic busy_out,
   output logic nack_out,
   output logic [31:0] rdata_out
);
   typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_STOP} mlim_mst_t;
   typedef struct packed {
      logic [1:0] sda_s;
      mlim_mst_t st;
      logic [15:0] cnt;
      logic [1:0] ph;
      logic [3:0] bitn;
      logic [3:0] bytes;
      logic [3:0] total;
      logic rd;
      logic [39:0] tx;
      logic [31:0] rx;
      logic [7:0] cur;
      logic scl;
      logic sda;
      logic nack;
   } mlim_m_state_t;
   mlim_m_state_t r;
   mlim_m_state_t next_r;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      next_r = r;
      next_r.sda_s = {r.sda_s[0], bus.sda};
      next_r.cnt = r.cnt + 16'h0001;
      case (r.st)
         M_IDLE:
         begin
            next_r.cnt = 16'h0000;
            if (go_in)
            begin
               next_r.st = M_START;
               next_r.rd = rd_in;
               next_r.total = nbytes_in;
               next_r.bytes = 4'h0;
               next_r.tx = {addr_in, rd_in, wdata_in};
               next_r.nack = 1'b0;
            end
         end
         M_START:
            if (r.cnt == 16'(mlim_pkg::SCL_QUARTER))
               next_r.sda = 1'b0;
            else if (r.cnt == 16'(2 * mlim_pkg::SCL_QUARTER))
            begin
               next_r.scl = 1'b0;
               next_r.cnt = 16'h0000;
               next_r.ph = 2'h0;
               next_r.bitn = 4'h0;
               next_r.st = M_BIT;
            end
         M_BIT:
            if (r.cnt == 16'(mlim_pkg::SCL_QUARTER))
            begin
               next_r.cnt = 16'h0000;
               next_r.ph = r.ph + 2'h1;
               case (r.ph)
                  2'h0:
                     if (r.bitn == 4'h8)
                        next_r.sda = !(r.rd && r.bytes != 4'h0 && r.bytes < r.total);
                     else
                        next_r.sda = (r.rd && r.bytes != 4'h0) ? 1'b1 : r.tx[39];
                  2'h1:
                     next_r.scl = 1'b1;
                  2'h2:
                  begin
                     if (r.bitn == 4'h8 && (!r.rd || r.bytes == 4'h0) && r.sda_s[1])
                        next_r.nack = 1'b1;
                     if (r.bitn != 4'h8)
                     begin
                        next_r.cur = {r.cur[6:0], r.sda_s[1]};
                        if (!(r.rd && r.bytes != 4'h0))
                           next_r.tx = {r.tx[38:0], 1'b0};
                     end
                  end
                  default:
                  begin
                     next_r.scl = 1'b0;
                     if (r.bitn == 4'h8)
                     begin
                        next_r.bitn = 4'h0;
                        next_r.bytes = r.bytes + 4'h1;
                        if (r.rd && r.bytes != 4'h0)
                           next_r.rx = {r.rx[23:0], r.cur};
                        if (r.nack || r.bytes == r.total)
                        begin
                           next_r.st = M_STOP;
                           next_r.ph = 2'h0;
                        end
                     end
                     else
                        next_r.bitn = r.bitn + 4'h1;
                  end
               endcase
            end
         M_STOP:
            if (r.cnt == 16'(mlim_pkg::SCL_QUARTER))
            begin
               next_r.cnt = 16'h0000;
               next_r.ph = r.ph + 2'h1;
               case (r.ph)
                  2'h0:
                     next_r.sda = 1'b0;
                  2'h1:
                     next_r.scl = 1'b1;
                  default:
                  begin
                     next_r.sda = 1'b1;
                     next_r.st = M_IDLE;
                  end
               endcase
            end
         default:
            next_r.st = M_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         r <= '0;
         r.sda_s <= 2'h3;
         r.st <= M_IDLE;
         r.scl <= 1'b1;
         r.sda <= 1'b1;
      end
      else
         r <= next_r;
   end

   assign bus.scl_out = 1'b0;
   assign bus.scl_oe = !r.scl;
   assign bus.sda_m_out = 1'b0;
   assign bus.sda_m_oe = !r.sda;
   assign busy_out = r.st != M_IDLE;
   assign nack_out = r.nack;
   assign rdata_out = r.rx;
endmodule

// ===== mlim_props.sv
`timescale 1ns/1ps
module mlim_props (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic scl,
   input wire logic sda,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_m_out,
   input wire logic sda_m_oe,
   input wire logic sda_s_out,
   input wire logic sda_s_oe
);
   // ---------------------------------------------------------------
   // Bit count since the last start, and direction of the frame
   // ---------------------------------------------------------------
   logic [7:0] cnt;
   logic rdir;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence s_start;
      scl && $past(scl) && $fell(sda);
   endsequence

   sequence s_stop;
      scl && $past(scl) && $rose(sda);
   endsequence

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cnt <= 8'h00;
         rdir <= 1'h0;
      end
      else if (scl && $past(scl) && $fell(sda))
      begin
         cnt <= 8'h00;
      end
      else if ($rose(scl))
      begin
         cnt <= cnt + 8'h01;
         if (cnt == 8'h07)
         begin
            rdir <= sda;
         end
      end
   end

   // ---------------------------------------------------------------
   // Line checks
   // ---------------------------------------------------------------
   a_start_by_master: assert property (s_start |-> sda_m_oe && !sda_s_oe)
      else $error("start not made by the master");
   a_clock_after_start: assert property (s_start |-> ##[1:300] !scl)
      else $error("clock did not follow a start");
   a_stop_by_master: assert property (s_stop |-> $past(sda_m_oe) && !sda_s_oe)
      else $error("stop not made by the master");
   a_idle_after_stop: assert property (s_stop |=> scl [*8])
      else $error("clock not idle after stop");
   a_frame_nine_bits: assert property (s_stop |-> (cnt % 8'h09) == 8'h01)
      else $error("frame not a whole number of nine-bit units");
   a_slave_data_steady: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
      else $error("slave changed data while clock high");
   a_addr_phase_silent: assert property (sda_s_oe |-> cnt >= 8'h08)
      else $error("slave drove data during the address byte");
   a_slave_bit_slots: assert property ($rose(scl) && sda_s_oe |->
      (cnt == 8'h08) || (rdir ? (cnt % 8'h09) != 8'h08 : (cnt % 8'h09) == 8'h08))
      else $error("slave drove data outside its slots");
   a_open_drain_only: assert property (!(scl_oe && scl_out) && !(sda_s_oe && sda_s_out))
      else $error("line driven high instead of released");
endmodule

// ===== test_monitor_i2c_slave_limit_regs.sv
`timescale 1ns/1ps
module test_monitor_i2c_slave_limit_regs;
   localparam logic [6:0] SA = 7'h70;
   logic ref_clk_in = 1'h0;
   logic rst_n_in = 1'h0;
   logic go = 1'h0;
   logic [6:0] addr = 7'h00;
   logic rd = 1'h0;
   logic [3:0] nbytes = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [11:0] raw_a = 12'h000;
   logic [11:0] raw_b = 12'h000;
   logic tvalid = 1'h0;
   logic busy;
   logic nack;
   logic [31:0] rdata;
   logic [11:0] res_a;
   logic [11:0] res_b;
   logic [3:0] minmax;
   logic [6:0] slave_addr;
   int fails = 0;
   int comparisons = 0;

   mlim_if bus_if ();

   always #5 ref_clk_in = ~ref_clk_in;

   mlim_slave #(
      .DIFF_MODE(4'h0)
   ) mlim_slave_inst (
      .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus(bus_if),
      .addr_strap_msb_in(2'h1), .addr_strap_mid_in(2'h2), .addr_strap_lsb_in(2'h0),
      .temp_a_raw_in(raw_a), .temp_b_raw_in(raw_b), .temp_valid_in(tvalid),
      .temp_a_result_out(res_a), .temp_b_result_out(res_b),
      .minmax_mode_out(minmax), .slave_addr_out(slave_addr)
   );

   mlim_master mlim_master_inst (
      .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus(bus_if),
      .go_in(go), .addr_in(addr), .rd_in(rd), .nbytes_in(nbytes), .wdata_in(wdata),
      .busy_out(busy), .nack_out(nack), .rdata_out(rdata)
   );

   mlim_props mlim_props_inst (
      .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .scl(bus_if.scl), .sda(bus_if.sda),
      .scl_out(bus_if.scl_out), .scl_oe(bus_if.scl_oe), .sda_m_out(bus_if.sda_m_out),
      .sda_m_oe(bus_if.sda_m_oe), .sda_s_out(bus_if.sda_s_out), .sda_s_oe(bus_if.sda_s_oe)
   );

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
      begin
         $display("TEST PASSED");
      end
      else
      begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic xfer(input logic [6:0] a, input logic r, input logic [3:0] n, input logic [31:0] d);
      int k;
      @(posedge ref_clk_in);
      go <= 1'h1;
      addr <= a;
      rd <= r;
      nbytes <= n;
      wdata <= d;
      @(posedge ref_clk_in);
      go <= 1'h0;
      repeat (3) @(negedge ref_clk_in);
      k = 0;
      while (busy !== 1'h0 && k < 100000)
      begin
         @(negedge ref_clk_in);
         k++;
      end
      check("busy", 32'h0, 32'(busy));
   endtask

   task automatic temp_sample(input logic [11:0] a, input logic [11:0] b);
      @(posedge ref_clk_in);
      raw_a <= a;
      raw_b <= b;
      tvalid <= 1'h1;
      @(posedge ref_clk_in);
      tvalid <= 1'h0;
      repeat (3) @(negedge ref_clk_in);
   endtask

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (12) @(posedge ref_clk_in);
      rst_n_in <= 1'h1;
      repeat (4) @(negedge ref_clk_in);
      check("slave_addr", 32'h70, 32'(slave_addr));
      check("minmax", 32'h0, 32'(minmax));
      xfer(SA, 1'h0, 4'h1, 32'h1000_0000);
      xfer(SA, 1'h1, 4'h2, 32'h0);
      check("hyst1", 32'h0008, 32'(rdata[15:0]));
      check("nack", 32'h0, 32'(nack));
      xfer(SA, 1'h0, 4'h3, 32'h0D7F_FF00);
      check("minmax", 32'h1, 32'(minmax));
      xfer(SA, 1'h1, 4'h2, 32'h0);
      check("hyst0", 32'h0FFF, 32'(rdata[15:0]));
      xfer(SA, 1'h0, 4'h4, 32'h26FC_2705);
      xfer(SA, 1'h1, 4'h1, 32'h0);
      check("offset2", 32'h05, 32'(rdata[7:0]));
      temp_sample(12'h100, 12'h100);
      check("res_a", 32'h104, 32'(res_a));
      check("res_b", 32'h0FB, 32'(res_b));
      xfer(SA ^ 7'h01, 1'h0, 4'h1, 32'h0A00_0000);
      check("nack", 32'h1, 32'(nack));
      xfer(SA, 1'h0, 4'h2, 32'h0AB0_0000);
      check("slave_addr", 32'h10, 32'(slave_addr));
      xfer(SA, 1'h0, 4'h2, 32'h0A30_0000);
      check("nack", 32'h1, 32'(nack));
      xfer(7'h10, 1'h0, 4'h2, 32'h0A30_0000);
      check("slave_addr", 32'h70, 32'(slave_addr));
      xfer(SA, 1'h0, 4'h1, 32'h1D00_0000);
      xfer(SA, 1'h1, 4'h4, 32'h0);
      check("temp_limit", 32'h03FF_03FF, rdata);
      print_verdict();
   end

   initial
   begin
      #950_000;
      $display("Error watchdog expected done seen running");
      fails++;
      print_verdict();
   end
endmodule
